/* File: verilog/mdd_datapath.sv */
// multiply, multiply-accumulate, square and conditional-subtract datapath
`timescale 1ns/1ns
`include "mdd_defines.svh"

// Operation
// RULE1 - signed 16x16 gives 32-bit product, one cycle
// RULE2 - unsigned multiply treats operands as magnitudes
// RULE3 - hold register times operand into product register
// RULE4 - software moves product before next multiply
// RULE5 - mul_acc: accumulate, fetch, multiply; four cycles
// RULE6 - data from blocks one/two, program from zero
// RULE7 - repeated mul_acc iterations take one cycle
// RULE8 - square add/subtract then square, one cycle
// RULE9 - shift select scales transfer, product unshifted
// RULE10 - sixteen steps leave quotient low, remainder high
// RULE11 - subtract divisor<<15, keep and set LSB if non-negative
// RULE12 - software supplies positive operands, fixes sign
// RULE13 - numerator/denominator magnitude order per division kind
// RULE14 - select 11 drops six LSBs, sign-fills top
// RULE15 - 32-bit accumulator, separately written halves
module mdd_datapath #(
  parameter int REPEAT_WIDTH = 8
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    opValid,
  input  wire mdd_pkg::mdd_op_type     opCode,
  input  wire logic [15:0]             dataWord,
  input  wire logic [15:0]             progWord,
  input  wire logic [1:0]              productShiftSel,
  input  wire logic [REPEAT_WIDTH-1:0] repeatCount,
  input  wire logic                    accWriteHigh,
  input  wire logic                    accWriteLow,
  input  wire logic [15:0]             accWriteData,
  output logic                         busy,
  output logic                         operandFetch,
  output logic                         dataMoveStrobe,
  output logic [15:0]                  holdReg,
  output logic [31:0]                  productReg,
  output logic [31:0]                  accReg
);
  import mdd_pkg::*;

  // ==========================================================
  // arithmetic helpers
  // ==========================================================
  // signed and unsigned products are formed separately; uns picks one
  function automatic logic [31:0] mulFn(input logic [15:0] a, input logic [15:0] b,
                                        input logic uns);
    logic [31:0] sProd;
    logic [31:0] uProd;
    // both operands widened with their sign so no tool sizes the product at 16 bits
    sProd = $signed({{16{a[15]}}, a}) * $signed({{16{b[15]}}, b});
    uProd = 32'({16'h0000, a} * {16'h0000, b});
    mulFn = uns ? uProd : sProd;
  endfunction

  // scales the product only on its path to the accumulator
  function automatic logic [31:0] shiftFn(input logic [31:0] p, input logic [1:0] sel);
    case (sel)
      `MDD_SHIFT_LEFT1:  shiftFn = p << 1;
      `MDD_SHIFT_LEFT4:  shiftFn = p << `MDD_LEFT4_AMOUNT;
      `MDD_SHIFT_RIGHT6: shiftFn = 32'($signed(p) >>> `MDD_RIGHT_DROP); // RULE14
      default:           shiftFn = p;
    endcase
  endfunction

  // ==========================================================
  // sequencing of repeated multiply-accumulate
  // ==========================================================
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_RUN} mdd_state_type;

  mdd_state_type             stateReg;    // sequencer state
  mdd_state_type             stateNext;
  logic [1:0]                setupReg;    // pipeline fill cycles left
  logic [REPEAT_WIDTH-1:0]   iterReg;     // iterations still to run after this one
  logic                      withMoveReg; // running the move variant

  wire issue      = opValid && (stateReg == ST_IDLE);
  wire isMacOp    = (opCode == MDD_OP_MUL_ACC) || (opCode == MDD_OP_MUL_ACC_WITH_MOVE);
  wire startMac   = issue && isMacOp;
  wire setupDone  = (stateReg == ST_SETUP) && (setupReg == 2'h1);
  wire macStep    = (stateReg == ST_RUN);
  wire lastStep   = macStep && (iterReg == '0);

  // busy holds off new operations; the issue cycle itself is not flagged
  assign busy           = (stateReg != ST_IDLE);
  // operands are read from the buses in each accumulate cycle
  assign operandFetch   = macStep; // RULE6
  assign dataMoveStrobe = macStep && withMoveReg;

  // next-state decode
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_IDLE:  if (startMac) stateNext = ST_SETUP;
      ST_SETUP: if (setupDone) stateNext = ST_RUN;
      ST_RUN:   if (lastStep) stateNext = ST_IDLE;
      default:  stateNext = ST_IDLE;
    endcase
  end

  // state and counters; overhead of three fill cycles is paid once per repeat
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg    <= ST_IDLE;
      setupReg    <= 2'h0;
      iterReg     <= '0;
      withMoveReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      if (startMac) begin
        setupReg    <= `MDD_MAC_SETUP_CYCLES - 2'h1; // RULE5
        iterReg     <= repeatCount;
        withMoveReg <= (opCode == MDD_OP_MUL_ACC_WITH_MOVE);
      end else if (stateReg == ST_SETUP) begin
        setupReg <= setupReg - 2'h1;
      end else if (macStep && !lastStep) begin
        iterReg <= iterReg - 1'b1; // RULE7
      end
    end
  end

  // ==========================================================
  // datapath next values
  // ==========================================================
  wire [31:0] shiftedProduct = shiftFn(productReg, productShiftSel); // RULE9
  wire [31:0] divisorAligned = {16'h0000, dataWord} << `MDD_DIVISOR_SHIFT;
  wire [31:0] subDiff        = accReg - divisorAligned;
  // positive operands only; the sign bit of the difference decides the step
  wire [31:0] condSubResult  = subDiff[31] ? (accReg << 1)
                                           : ((subDiff << 1) | 32'h0000_0001); // RULE11
  wire        isSqa          = issue && (opCode == MDD_OP_SQUARE_ADD);
  wire        isSqs          = issue && (opCode == MDD_OP_SQUARE_SUBTRACT);
  wire        isMpy          = issue && (opCode == MDD_OP_MULTIPLY);
  wire        isMpyu         = issue && (opCode == MDD_OP_UNSIGNED_MULTIPLY);
  wire        isSubc         = issue && (opCode == MDD_OP_COND_SUB_STEP);
  wire        isApac         = issue && (opCode == MDD_OP_ADD_PRODUCT);
  wire        isLoadHold     = issue && (opCode == MDD_OP_LOAD_HOLD);

  logic [31:0] accNext;
  logic [31:0] productNext;

  // accumulator source selection; full-width for all arithmetic
  always_comb begin
    accNext = accReg;
    if (macStep || isSqa || isApac) begin
      accNext = accReg + shiftedProduct; // RULE5 RULE8
    end else if (isSqs) begin
      accNext = accReg - shiftedProduct; // RULE8
    end else if (isSubc) begin
      accNext = condSubResult; // RULE10 RULE15
    end else begin
      if (accWriteHigh) accNext[31:16] = accWriteData; // RULE15
      if (accWriteLow)  accNext[15:0]  = accWriteData; // RULE15
    end
  end

  // product register source; a new multiply replaces the held product
  always_comb begin
    productNext = productReg;
    if (macStep) begin
      productNext = mulFn(dataWord, progWord, 1'b0); // RULE6
    end else if (isSqa || isSqs) begin
      productNext = mulFn(dataWord, dataWord, 1'b0); // RULE8
    end else if (isMpy || isMpyu) begin
      productNext = mulFn(holdReg, dataWord, isMpyu); // RULE1 RULE2 RULE3
    end
  end

  // ==========================================================
  // storage
  // ==========================================================
  // registers stay short; all selection happens above
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdReg    <= 16'h0000;
      productReg <= 32'h0000_0000;
      accReg     <= 32'h0000_0000;
    end else begin
      if (isLoadHold) holdReg <= dataWord; // RULE3
      productReg <= productNext;
      accReg     <= accNext;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  sequence macIssue_s;
    opValid && !busy && isMacOp && (repeatCount == '0);
  endsequence
  sequence macFill_s;
    (stateReg == ST_SETUP) [*2];
  endsequence

  signedMul_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    isMpy |=> $signed(productReg) == $signed($past(holdReg)) * $signed($past(dataWord)))
    else $error("signed product wrong");
  unsignedMul_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    isMpyu |=> productReg == 32'({16'h0000, $past(holdReg)} * {16'h0000, $past(dataWord)}))
    else $error("unsigned product wrong");
  holdLoad_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    isLoadHold |=> holdReg == $past(dataWord))
    else $error("hold register not loaded");
  macFour_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    macIssue_s ##1 macFill_s |=> operandFetch ##1 !busy)
    else $error("standalone mul_acc not four cycles");
  macRepeat_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    operandFetch && $past(operandFetch) |->
      accReg == $past(accReg) + shiftFn($past(productReg), $past(productShiftSel)) ##0 1'b1)
    else $error("repeated step not single cycle");
  squareSub_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    isSqs |=> accReg == $past(accReg) - shiftFn($past(productReg), $past(productShiftSel))
              && $signed(productReg) == $signed($past(dataWord)) * $signed($past(dataWord)))
    else $error("square subtract wrong");
  productKept_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    isApac |=> productReg == $past(productReg))
    else $error("transfer altered product");
  rightSix_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    isApac && productShiftSel == 2'h3 |=>
      accReg == $past(accReg) + {{6{$past(productReg[31])}}, $past(productReg[31:6])})
    else $error("right shift transfer wrong");
  condSub_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    isSubc && !subDiff[31] |=> accReg[0] && accReg[31:1] == $past(subDiff[30:0]))
    else $error("conditional subtract wrong");
  // every step but the last is followed at once by the next one
  macSingle_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    operandFetch && !lastStep |=> operandFetch)
    else $error("repeated step not back to back");
  // a lone low-half write leaves the high half alone
  accLowWrite_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    accWriteLow && !accWriteHigh && !(macStep || isSqa || isSqs || isSubc || isApac) |=>
      accReg[15:0] == $past(accWriteData) && accReg[31:16] == $past(accReg[31:16]))
    else $error("low half write wrong");
endmodule

/* File: verilog/mdd_defines.svh */
// timing, field and encoding constants of the multiply/divide datapath
`ifndef MDD_DEFINES_SVH
`define MDD_DEFINES_SVH
`define MDD_MAC_SETUP_CYCLES 2'h3
`define MDD_SHIFT_NONE       2'h0
`define MDD_SHIFT_LEFT1      2'h1
`define MDD_SHIFT_LEFT4      2'h2
`define MDD_SHIFT_RIGHT6     2'h3
`define MDD_DIVISOR_SHIFT    15
`define MDD_RIGHT_DROP       6
`define MDD_LEFT4_AMOUNT     4
`endif

/* File: verilog/mdd_pkg.sv */
// types shared by the multiply/divide datapath
package mdd_pkg;
  // operations issued by the instruction stream
  typedef enum logic [3:0] {
    MDD_OP_LOAD_HOLD,
    MDD_OP_MULTIPLY,
    MDD_OP_UNSIGNED_MULTIPLY,
    MDD_OP_MUL_ACC,
    MDD_OP_MUL_ACC_WITH_MOVE,
    MDD_OP_SQUARE_ADD,
    MDD_OP_SQUARE_SUBTRACT,
    MDD_OP_COND_SUB_STEP,
    MDD_OP_ADD_PRODUCT
  } mdd_op_type;
endpackage

/* File: tb/multiply_divide_datapath_test.sv */
// self-checking random bench for the multiply/divide datapath
`timescale 1ns/1ns
module multiply_divide_datapath_test;
  import mdd_pkg::*;
  // ==========================================================
  // stimulus, observed outputs and reference model state
  logic        clk = 1'b0;                        // 10 MHz core clock
  logic        rst_n = 1'b0;                      // async reset, active low
  logic        opValid = 1'b0;                    // request, kept up between ops
  mdd_op_type  opCode = MDD_OP_LOAD_HOLD;         // operation code
  logic [15:0] dataWord = 16'h0000;               // data-bus operand
  logic [15:0] progWord = 16'h0000;               // program-bus operand
  logic [1:0]  productShiftSel = 2'h0;            // transfer shift select
  logic [7:0]  repeatCount = 8'h00;               // iterations minus one
  logic        accWriteHigh = 1'b0;               // direct write, upper half
  logic        accWriteLow = 1'b0;                // direct write, lower half
  logic [15:0] accWriteData = 16'h0000;           // direct write data
  logic        busy, operandFetch, dataMoveStrobe; // sequencer status
  logic [15:0] holdReg;                           // multiplicand hold
  logic [31:0] productReg, accReg;                // product and accumulator
  logic [15:0] mHold = 16'h0000;                  // model of holdReg
  logic [31:0] mProd = 32'h00000000;              // model of productReg
  logic [31:0] mAcc = 32'h00000000;               // model of accReg
  int          err_count = 0;                     // mismatches
  int          n_compared = 0;                    // comparisons made
  int          seed = 14694;                      // fixed seed, repeatable run
  int          cycles = 0;                        // watchdog count
  mdd_op_type  tbl [7] = '{MDD_OP_LOAD_HOLD, MDD_OP_MULTIPLY, MDD_OP_UNSIGNED_MULTIPLY,
    MDD_OP_SQUARE_ADD, MDD_OP_SQUARE_SUBTRACT, MDD_OP_COND_SUB_STEP, MDD_OP_ADD_PRODUCT};
  mdd_datapath #(.REPEAT_WIDTH(8)) DUT (.clk(clk), .rst_n(rst_n), .opValid(opValid),
    .opCode(opCode), .dataWord(dataWord), .progWord(progWord),
    .productShiftSel(productShiftSel), .repeatCount(repeatCount),
    .accWriteHigh(accWriteHigh), .accWriteLow(accWriteLow), .accWriteData(accWriteData),
    .busy(busy), .operandFetch(operandFetch), .dataMoveStrobe(dataMoveStrobe),
    .holdReg(holdReg), .productReg(productReg), .accReg(accReg));
  // ==========================================================
  // clock and watchdog; the ceiling is far above the planned run
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  // ==========================================================
  // expectation helpers
  function automatic logic [31:0] sh(logic [31:0] p, logic [1:0] s);
    case (s)
      2'h0: return p;
      2'h1: return p << 1;
      2'h2: return p << 4;
      default: return {{6{p[31]}}, p[31:6]};
    endcase
  endfunction
  // signed unless u; truncation to 32 bits is exact for 16x16
  function automatic logic [31:0] mul(logic [15:0] x, logic [15:0] y, logic u);
    if (u) return {16'h0000, x} * {16'h0000, y};
    return $signed({{16{x[15]}}, x}) * $signed({{16{y[15]}}, y});
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // registers seen at an edge reflect every operation taken before it
  task automatic chkAll();
    check("holdReg", {16'h0000, holdReg}, {16'h0000, mHold});
    check("productReg", productReg, mProd);
    check("accReg", accReg, mAcc);
  endtask
  // ==========================================================
  // single-cycle operation; opValid stays up so calls run back to back
  task automatic op(mdd_op_type c, logic [15:0] d, logic [1:0] s);
    logic [31:0] diff;
    opValid <= 1'b1;
    opCode <= c;
    dataWord <= d;
    productShiftSel <= s;
    @(posedge clk);
    chkAll();
    diff = mAcc - ({16'h0000, d} << 15);
    case (c)
      MDD_OP_LOAD_HOLD: mHold = d;
      MDD_OP_MULTIPLY: mProd = mul(mHold, d, 1'b0);
      MDD_OP_UNSIGNED_MULTIPLY: mProd = mul(mHold, d, 1'b1);
      MDD_OP_SQUARE_ADD: {mAcc, mProd} = {mAcc + sh(mProd, s), mul(d, d, 1'b0)};
      MDD_OP_SQUARE_SUBTRACT: {mAcc, mProd} = {mAcc - sh(mProd, s), mul(d, d, 1'b0)};
      MDD_OP_COND_SUB_STEP: mAcc = diff[31] ? {mAcc[30:0], 1'b0} : {diff[30:0], 1'b1};
      default: mAcc = mAcc + sh(mProd, s);
    endcase
  endtask
  // quiet cycle that also compares the state reached so far
  task automatic idle();
    opValid <= 1'b0;
    @(posedge clk);
    chkAll();
  endtask
  // direct half writes while no arithmetic runs
  task automatic wacc(logic [31:0] v);
    opValid <= 1'b0;
    accWriteHigh <= 1'b1;
    accWriteData <= v[31:16];
    @(posedge clk);
    chkAll();
    accWriteHigh <= 1'b0;
    accWriteLow <= 1'b1;
    accWriteData <= v[15:0];
    @(posedge clk);
    accWriteLow <= 1'b0;
    mAcc = v;
  endtask
  // multiply-accumulate sequence with n iterations and fresh operands every cycle
  task automatic macc(mdd_op_type c, int n, logic [1:0] s);
    int nb = 0;
    int nf = 0;
    opValid <= 1'b1;
    opCode <= c;
    repeatCount <= 8'(n - 1);
    productShiftSel <= s;
    @(posedge clk);
    chkAll();
    opValid <= 1'b0;
    repeat (300) begin
      dataWord <= 16'($random(seed));
      progWord <= 16'($random(seed));
      @(posedge clk);
      if (operandFetch === 1'b1) begin
        nf++;
        check("dataMoveStrobe", 32'(dataMoveStrobe), 32'(c == MDD_OP_MUL_ACC_WITH_MOVE));
        {mAcc, mProd} = {mAcc + sh(mProd, s), mul(dataWord, progWord, 1'b0)};
      end
      if (busy !== 1'b1) break;
      nb++;
    end
    check("fetch count", nf, n);
    check("busy cycles", nb, n + 2);
  endtask
  task automatic print_verdict();
    $display("counts: compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] num;
    logic [15:0] den;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    idle();
    // sign corners of both multiplies, then every transfer shift
    op(MDD_OP_LOAD_HOLD, 16'h8000, 2'h0);
    op(MDD_OP_MULTIPLY, 16'h8000, 2'h0);
    op(MDD_OP_UNSIGNED_MULTIPLY, 16'hFFFF, 2'h0);
    op(MDD_OP_LOAD_HOLD, 16'hFFFF, 2'h0);
    op(MDD_OP_MULTIPLY, 16'h7FFF, 2'h0);
    for (int s = 0; s < 4; s++) op(MDD_OP_ADD_PRODUCT, 16'h0000, 2'(s));
    $display("test multiply corners done");
    // positive operands only, numerator strictly above denominator
    for (int k = 0; k < 20; k++) begin
      num = (k == 0) ? 16'h0021 : 16'h0002 + 16'($unsigned($random(seed)) % 32766);
      den = (k == 0) ? 16'h0005
                     : 16'h0001 + 16'($unsigned($random(seed)) % (num - 16'h0001));
      wacc({16'h0000, num});
      repeat (16) op(MDD_OP_COND_SUB_STEP, den, 2'h0);
      idle();
      check("quotient and remainder", accReg, {num % den, num / den});
    end
    $display("test division done");
    macc(MDD_OP_MUL_ACC, 1, 2'h0);
    macc(MDD_OP_MUL_ACC_WITH_MOVE, 5, 2'h1);
    macc(MDD_OP_MUL_ACC, 8, 2'h3);
    macc(MDD_OP_MUL_ACC_WITH_MOVE, 1 + $unsigned($random(seed)) % 16, 2'h2);
    $display("test multiply-accumulate done");
    repeat (300) op(tbl[$unsigned($random(seed)) % 7], 16'($random(seed)), 2'($random(seed)));
    idle();
    $display("test random operations done");
    print_verdict();
  end
endmodule
